// >>> hdl/tcf_map.svh
// register map, fields and constants for the tape character format control
//
// Overview of operation
// - four-bit format select in bits 7..4; 1100 normal, 1101 core dump.
// - data transfer with go and unsupported format sets format error, aborts.
// - nrz with even parity bit set: write even parity, check even parity.
// - nrz with even parity bit clear: write odd parity, check odd parity.
// - nrz even parity never records zero: invert bit 4 and parity, 000 to 020.
// - phase encoded mode (density msb one) ignores even parity, uses odd.
// - three-bit transport select in bits 2..0 picks unit for later commands.
// - drive clear and bus initialize leave transport select unchanged.
// - density field bits 10..8: 200, 556, 800, 800, 1600 pe, rest reserved.
// - drive clear and bus initialize leave density select unchanged.
`ifndef TCF_MAP_SVH
`define TCF_MAP_SVH

`define TCF_ADDR_CTRL 4'h0
`define TCF_ADDR_CMD 4'h4
`define TCF_ADDR_ERR 4'h8
`define TCF_ADDR_STAT 4'hc
`define TCF_ADDR_MASK 4'h0
`define TCF_ADDR_MASK_HI 1'b1
`define TCF_ADDR_NONE 4'h1
`define TCF_ADDR_DEC_W 4

`define TCF_FMT_LSB 4
`define TCF_FMT_MSB 7
`define TCF_EVPAR_BIT 3
`define TCF_UNIT_MSB 2
`define TCF_DEN_LSB 8
`define TCF_DEN_MSB 10
`define TCF_FERR_BIT 4
`define TCF_CHAR_BIT4 4

`define TCF_FMT_NORMAL 4'hc
`define TCF_FMT_COREDUMP 4'hd
`define TCF_DEN_PE_BIT 2
`define TCF_CTRL_RW_MASK 16'h07ff
`define TCF_CTRL_RST 11'h000

`define TCF_CMD_GO_BIT 0
`define TCF_CMD_XFER_BIT 1
`define TCF_CMD_CLR_BIT 2

`define TCF_IRQ_ABORT 0
`define TCF_IRQ_START 1
`define TCF_IRQ_PERR 2

`endif

// >>> hdl/tcf_pkg.sv
// types shared by the tape character format control
`default_nettype none
package tcf_pkg;
   typedef struct packed {
      logic [2:0] density;
      logic [3:0] format;
      logic even_parity;
      logic [2:0] unit;
   } tcf_ctrl_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic parity;
   } tcf_char_t;

   typedef enum logic [1:0] {
      TCF_IDLE = 2'b00,
      TCF_RUN = 2'b01,
      TCF_ABORT = 2'b10
   } tcf_state_t;
endpackage : tcf_pkg
`default_nettype wire

// >>> hdl/tcf_char_codec.sv
// per-character parity for write and read paths, zero substitution on the write path only
`timescale 1ns/1ps
`default_nettype none
`include "tcf_map.svh"
module tcf_char_codec
(
   input wire logic pe_mode,
   input wire logic even_parity,
   input wire logic [7:0] wr_data,
   output logic [7:0] tape_data,
   output logic tape_parity,
   input wire logic [7:0] rd_data,
   input wire logic rd_parity,
   output logic rd_parity_err
);
   logic use_even;
   logic wr_par;
   logic zero_sub;

   always_comb
   begin
      use_even = even_parity & ~pe_mode;
      wr_par = use_even ? ^wr_data : ~(^wr_data);
      zero_sub = use_even && (wr_data == 8'h00);
      tape_data = wr_data;
      tape_parity = wr_par;
      if (zero_sub)
      begin
         tape_data[`TCF_CHAR_BIT4] = ~wr_data[`TCF_CHAR_BIT4];
         tape_parity = ~wr_par;
      end
      rd_parity_err = use_even ? (^{rd_data, rd_parity}) : ~(^{rd_data, rd_parity});
   end
endmodule : tcf_char_codec
`default_nettype wire

// >>> hdl/tcf_top.sv
// tape character format control with axi4-lite register slave
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tcf_map.svh"
module tcf_top
#(
   parameter int ADDR_W = 4
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic drive_clear,
   input wire logic bus_init,
   input wire logic [7:0] host_wr_char,
   input wire logic host_wr_valid,
   output logic [7:0] tape_wr_char,
   output logic tape_wr_parity,
   output logic tape_wr_valid,
   input wire logic [7:0] tape_rd_char,
   input wire logic tape_rd_parity,
   input wire logic tape_rd_valid,
   output logic [7:0] host_rd_char,
   output logic host_rd_valid,
   output logic [2:0] transport_unit_select,
   output logic [3:0] char_format_select,
   output logic [2:0] density_select,
   output logic xfer_active,
   output logic irq
);
   if (ADDR_W < `TCF_ADDR_DEC_W)
   begin : g_addr_w_check
      $error("tcf_top: ADDR_W must be at least 4");
   end

   tcf_pkg::tcf_ctrl_t ctrl_q;
   tcf_pkg::tcf_state_t state_q;
   logic [15:0] error_register_q;
   logic [2:0] stat_q;
   logic [2:0] mask_q;
   logic aw_q, w_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_fire, rd_fire;
   logic [3:0] wa, ra;
   logic fmt_ok, go_xfer, go_any, do_clr;
   logic [2:0] ev;
   logic rd_stat;
   logic [7:0] enc_data;
   logic enc_par, dec_err;
   logic [7:0] wr_char_q, rd_char_q;
   logic wr_par_q, wr_vld_q, rd_vld_q;

   assign s_axi_awready = ~aw_q & ~bvalid_q;
   assign s_axi_wready = ~w_q & ~bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign wr_fire = aw_q & w_q & ~bvalid_q;
   assign rd_fire = s_axi_arvalid & ~rvalid_q;
   // upper address bits set means unmapped, no aliasing
   assign wa = (awaddr_q >> `TCF_ADDR_DEC_W) == '0 ? awaddr_q[3:0] : `TCF_ADDR_NONE;
   assign ra = (s_axi_araddr >> `TCF_ADDR_DEC_W) == '0 ? s_axi_araddr[3:0] : `TCF_ADDR_NONE;
   assign rd_stat = rd_fire && ra == `TCF_ADDR_STAT;

   // write address and data latches, either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_q <= 1'b0;
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= (wa == `TCF_ADDR_CTRL || wa == `TCF_ADDR_CMD || wa == `TCF_ADDR_ERR
                     || wa == `TCF_ADDR_STAT) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // command strobes from the command word
   always_comb
   begin
      go_any = wr_fire && wa == `TCF_ADDR_CMD && wstrb_q[0] && wdata_q[`TCF_CMD_GO_BIT];
      go_xfer = go_any && wdata_q[`TCF_CMD_XFER_BIT];
      do_clr = wr_fire && wa == `TCF_ADDR_CMD && wstrb_q[0] && wdata_q[`TCF_CMD_CLR_BIT];
      fmt_ok = ctrl_q.format == `TCF_FMT_NORMAL
               || ctrl_q.format == `TCF_FMT_COREDUMP;
   end

   // tape control register; reset only at power-up, clears leave all fields
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_q <= tcf_pkg::tcf_ctrl_t'(`TCF_CTRL_RST);
      else if (wr_fire && wa == `TCF_ADDR_CTRL)
      begin
         if (wstrb_q[0])
         begin
            ctrl_q.format <= wdata_q[`TCF_FMT_MSB:`TCF_FMT_LSB];
            ctrl_q.even_parity <= wdata_q[`TCF_EVPAR_BIT];
            ctrl_q.unit <= wdata_q[`TCF_UNIT_MSB:0];
         end
         if (wstrb_q[1])
            ctrl_q.density <= wdata_q[`TCF_DEN_MSB:`TCF_DEN_LSB];
      end
   end

   // transfer state: go with bad format aborts
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_q <= tcf_pkg::TCF_IDLE;
      else
      begin
         case (state_q)
            tcf_pkg::TCF_IDLE:
               if (go_xfer)
                  state_q <= fmt_ok ? tcf_pkg::TCF_RUN : tcf_pkg::TCF_ABORT;
            tcf_pkg::TCF_RUN:
               if (do_clr || drive_clear || bus_init)
                  state_q <= tcf_pkg::TCF_IDLE;
            tcf_pkg::TCF_ABORT:
               state_q <= tcf_pkg::TCF_IDLE;
            default:
               state_q <= tcf_pkg::TCF_IDLE;
         endcase
      end
   end

   assign ev[`TCF_IRQ_ABORT] = state_q == tcf_pkg::TCF_ABORT;
   assign ev[`TCF_IRQ_START] = go_xfer && fmt_ok && state_q == tcf_pkg::TCF_IDLE;
   assign ev[`TCF_IRQ_PERR] = tape_rd_valid && dec_err && state_q == tcf_pkg::TCF_RUN;

   // error register; set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         error_register_q <= 16'h0000;
      else if (ev[`TCF_IRQ_ABORT])
         error_register_q[`TCF_FERR_BIT] <= 1'b1;
      else if (do_clr || drive_clear || bus_init)
         error_register_q <= 16'h0000;
   end

   // sticky event status, cleared by read, set wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         stat_q <= 3'h0;
      else
         stat_q <= (rd_stat ? 3'h0 : stat_q) | ev;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_q <= 3'h0;
      else if (wr_fire && wa == `TCF_ADDR_ERR && wstrb_q[0])
         mask_q <= wdata_q[2:0];
   end

   assign irq = |(stat_q & mask_q);

   // read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'b00;
      end
      else if (rd_fire)
      begin
         rvalid_q <= 1'b1;
         rresp_q <= 2'b00;
         case (ra)
            `TCF_ADDR_CTRL: rdata_q <= {21'h0, ctrl_q};
            `TCF_ADDR_CMD: rdata_q <= {16'h0000, error_register_q};
            `TCF_ADDR_ERR: rdata_q <= {29'h0, mask_q};
            `TCF_ADDR_STAT: rdata_q <= {28'h0, state_q == tcf_pkg::TCF_RUN, stat_q};
            default:
            begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= 2'b10;
            end
         endcase
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   tcf_char_codec u_codec
   (
      .pe_mode(ctrl_q.density[`TCF_DEN_PE_BIT]),
      .even_parity(ctrl_q.even_parity),
      .wr_data(host_wr_char),
      .tape_data(enc_data),
      .tape_parity(enc_par),
      .rd_data(tape_rd_char),
      .rd_parity(tape_rd_parity),
      .rd_parity_err(dec_err)
   );

   // registered character paths, active only while running
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_char_q <= 8'h00;
         wr_par_q <= 1'b0;
         wr_vld_q <= 1'b0;
         rd_char_q <= 8'h00;
         rd_vld_q <= 1'b0;
      end
      else
      begin
         wr_vld_q <= host_wr_valid && state_q == tcf_pkg::TCF_RUN;
         rd_vld_q <= tape_rd_valid && state_q == tcf_pkg::TCF_RUN;
         if (host_wr_valid)
         begin
            wr_char_q <= enc_data;
            wr_par_q <= enc_par;
         end
         if (tape_rd_valid)
            rd_char_q <= tape_rd_char;
      end
   end

   assign tape_wr_char = wr_char_q;
   assign tape_wr_parity = wr_par_q;
   assign tape_wr_valid = wr_vld_q;
   assign host_rd_char = rd_char_q;
   assign host_rd_valid = rd_vld_q;
   assign transport_unit_select = ctrl_q.unit;
   assign char_format_select = ctrl_q.format;
   assign density_select = ctrl_q.density;
   assign xfer_active = state_q == tcf_pkg::TCF_RUN;
endmodule : tcf_top
`default_nettype wire

// >>> verif/tcf_properties.sv
// assertions on the tape character format control ports
`timescale 1ns/1ps
`default_nettype none
module tcf_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic drive_clear,
   input wire logic bus_init,
   input wire logic host_wr_valid,
   input wire logic [7:0] tape_wr_char,
   input wire logic tape_wr_parity,
   input wire logic tape_wr_valid,
   input wire logic [2:0] transport_unit_select,
   input wire logic [2:0] density_select,
   input wire logic [3:0] char_format_select,
   input wire logic xfer_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_clear_idle;
      (drive_clear || bus_init) && !s_axi_awvalid && !s_axi_wvalid;
   endsequence
   b_after_take_a: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("no write response");
   b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held");
   r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response held");
   char_follow_a: assert property (tape_wr_valid |-> $past(host_wr_valid))
      else $error("tape char without host char");
   pe_odd_par_a: assert property (tape_wr_valid && density_select[2] |-> ^{tape_wr_char, tape_wr_parity})
      else $error("pe char not odd");
   no_zero_char_a: assert property (tape_wr_valid && !(^{tape_wr_char, tape_wr_parity}) |-> tape_wr_char != 8'h00)
      else $error("zero char recorded");
   unit_keep_a: assert property (s_clear_idle |=> $stable(transport_unit_select))
      else $error("unit changed by clear");
   den_keep_a: assert property (s_clear_idle |=> $stable(density_select))
      else $error("density changed by clear");
   run_fmt_ok_a: assert property ($rose(xfer_active) |-> char_format_select inside {4'hc, 4'hd})
      else $error("transfer with bad format");
endmodule : tcf_checker
bind tcf_top tcf_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .drive_clear,
   .bus_init, .host_wr_valid, .tape_wr_char, .tape_wr_parity, .tape_wr_valid,
   .transport_unit_select, .density_select, .char_format_select, .xfer_active);
`default_nettype wire

// >>> verif/tcf_tape_model.sv
// tape transport model echoing recorded characters back
`timescale 1ns/1ps
`default_nettype none
module tcf_tape_model
(
   input wire logic aclk,
   input wire logic [7:0] wr_char,
   input wire logic wr_parity,
   input wire logic wr_valid,
   input wire logic bad_par,
   output logic [7:0] rd_char,
   output logic rd_parity,
   output logic rd_valid
);
   logic [7:0] char_q = 8'h00;
   logic par_q = 1'b0;
   logic valid_q = 1'b0;
   always @(posedge aclk)
   begin
      valid_q <= wr_valid;
      if (wr_valid)
      begin
         char_q <= wr_char;
         par_q <= wr_parity ^ bad_par;
      end
   end
   // lines between characters show inverted data
   assign rd_valid = valid_q;
   assign rd_char = valid_q ? char_q : ~char_q;
   assign rd_parity = valid_q ? par_q : ~par_q;
endmodule : tcf_tape_model
`default_nettype wire

// >>> verif/tcf_tb_top.sv
// testbench for the tape character format control
`timescale 1ns/1ps
`default_nettype none
module tcf_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00;
   logic [4:0] s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, drive_clear = 1'b0, bus_init = 1'b0;
   logic host_wr_valid = 1'b0, bad_par = 1'b0;
   logic [7:0] host_wr_char = 8'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
   logic [31:0] s_axi_rdata, d;
   logic [7:0] tape_wr_char, tape_rd_char, host_rd_char;
   logic tape_wr_parity, tape_wr_valid, tape_rd_parity, tape_rd_valid, host_rd_valid;
   logic [2:0] transport_unit_select, density_select;
   logic [3:0] char_format_select;
   logic xfer_active, irq;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   tcf_top #(.ADDR_W(5)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .drive_clear, .bus_init, .host_wr_char, .host_wr_valid,
      .tape_wr_char, .tape_wr_parity, .tape_wr_valid, .tape_rd_char, .tape_rd_parity,
      .tape_rd_valid, .host_rd_char, .host_rd_valid, .transport_unit_select,
      .char_format_select, .density_select, .xfer_active, .irq);
   tcf_tape_model i_tape (.aclk, .wr_char(tape_wr_char), .wr_parity(tape_wr_parity),
      .wr_valid(tape_wr_valid), .bad_par, .rd_char(tape_rd_char), .rd_parity(tape_rd_parity),
      .rd_valid(tape_rd_valid));
   initial forever #2 aclk = ~aclk;
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      b = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic put(input logic [7:0] c, input logic [7:0] x, input logic p);
      @(posedge aclk);
      host_wr_char <= c;
      host_wr_valid <= 1'b1;
      @(posedge aclk);
      host_wr_valid <= 1'b0;
      @(posedge aclk);
      chk({tape_wr_valid, tape_wr_char, tape_wr_parity}, {1'b1, x, p});
      repeat (2) @(posedge aclk);
      chk({host_rd_valid, host_rd_char}, {1'b1, x});
   endtask : put
   task automatic t_regs;
      rd(5'h00);
      chk(d, 32'h0);
      wr(5'h00, 32'hffffffff);
      chk(b, 2'b00);
      wr(5'h10, 32'h0);
      chk(b, 2'b10);
      rd(5'h00);
      chk(d, 32'h7ff);
      chk({char_format_select, transport_unit_select, density_select}, 10'h3ff);
      rd(5'h10);
      chk({r, d}, {2'b10, 32'h0});
      wr(5'h00, 32'h335);
      drive_clear <= 1'b1;
      @(posedge aclk);
      drive_clear <= 1'b0;
      bus_init <= 1'b1;
      @(posedge aclk);
      bus_init <= 1'b0;
      rd(5'h00);
      chk(d, 32'h335);
      chk({transport_unit_select, density_select}, {3'h5, 3'h3});
      $display("register test done");
   endtask : t_regs
   task automatic t_format;
      logic ok;
      wr(5'h08, 32'h1);
      for (int f = 0; f < 17; f++)
      begin
         ok = f == 12 || f == 13;
         if (f == 16) wr(5'h08, 32'h0);
         wr(5'h00, 32'((f % 16) << 4));
         wr(5'h04, 32'h3);
         rd(5'h04);
         chk(d[4], !ok);
         chk(xfer_active, ok);
         chk(irq, !ok && f < 16);
         rd(5'h0c);
         chk(d[3:0], {ok, 1'b0, ok, !ok});
         chk(irq, 1'b0);
         wr(5'h04, 32'h4);
      end
      $display("format test done");
   endtask : t_format
   task automatic t_parity;
      logic [7:0] x;
      logic e;
      for (int dn = 0; dn < 8; dn++)
         for (int ev = 0; ev < 2; ev++)
         begin
            e = ev && dn < 4;
            wr(5'h00, 32'(32'h0c2 | (dn << 8) | (ev << 3)));
            wr(5'h04, 32'h3);
            for (int c = 0; c < 256; c += 85)
            begin
               x = (e && c == 0) ? 8'h10 : 8'(c);
               put(8'(c), x, e ? ^x : ~^x);
            end
            rd(5'h0c);
            chk(d[2], 1'b0);
            wr(5'h04, 32'h4);
         end
      wr(5'h00, 32'h0c8);
      wr(5'h08, 32'h4);
      wr(5'h04, 32'h3);
      rd(5'h0c);
      bad_par <= 1'b1;
      put(8'h22, 8'h22, 1'b0);
      bad_par <= 1'b0;
      for (int i = 0; i < 8 && irq !== 1'b1; i++) @(posedge aclk);
      chk(irq, 1'b1);
      rd(5'h0c);
      chk(d[2], 1'b1);
      chk(irq, 1'b0);
      wr(5'h04, 32'h4);
      $display("parity test done");
   endtask : t_parity
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         close_out;
      end
   end
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_format;
      t_parity;
      close_out;
   end
endmodule : tcf_tb_top
`default_nettype wire
